// file: src/cfp_regs.vh
// Register map, field layout and constants of the fetch port block
`ifndef CFP_REGS_VH
`define CFP_REGS_VH
`define CFP_REG_CTRL 8'h00
`define CFP_REG_TARGET 8'h04
`define CFP_REG_STATUS 8'h08
`define CFP_REG_FETCH_DATA 8'h0C
`define CFP_REG_PC 8'h10
`define CFP_REG_COUNT 8'h14
`define CFP_CTRL_RUN 0
`define CFP_CTRL_ISA 1
`define CFP_CTRL_BRANCH 2
`define CFP_CTRL_DBGCLR 3
`define CFP_CTRL_MODE_LO 8
`define CFP_CTRL_MODE_HI 12
`define CFP_MODE_USER 5'h10
`define CFP_MODE_SVC 5'h13
`define CFP_RESET_PC 32'h00000000
`define CFP_ST_DEBUG 0
`define CFP_ST_ABORT 1
`define CFP_ST_RUN 2
`define CFP_ST_BUFV 3
`define CFP_RESP_OKAY 2'h0
`define CFP_RESP_SLVERR 2'h2
`endif

// file: src/cfp_buf2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module cfp_buf2 #(
    parameter WIDTH = 34
) (
    input wire sys_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_ff [0:1];
    reg wr_ptr_ff;
    reg rd_ptr_ff;
    reg [1:0] count_ff;
    wire push;
    wire pop;
    assign in_ready = (count_ff != 2'h2);
    assign out_valid = (count_ff != 2'h0);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                mem_ff[wr_ptr_ff] <= in_data;
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop)
                rd_ptr_ff <= ~rd_ptr_ff;
            if (push && !pop)
                count_ff <= count_ff + 2'h1;
            else if (pop && !push)
                count_ff <= count_ff - 2'h1;
        end
    end
endmodule
`default_nettype wire

// file: src/cfp_axil.v
// AXI4-Lite register slave for the fetch port block
`timescale 1ns/100ps
`default_nettype none
`include "cfp_regs.vh"
module cfp_axil (
    input wire sys_clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg wr_en,
    output reg [7:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    input wire wr_ok,
    output wire [7:0] rd_addr,
    input wire [31:0] rd_data,
    input wire rd_ok
);
    // ====================================================================
    // Write channel: address and data taken in either order
    reg aw_have_ff;
    reg w_have_ff;
    reg [7:0] aw_ff;
    reg [31:0] w_ff;
    reg [3:0] ws_ff;
    reg [7:0] ar_ff;
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_ff <= 8'h00;
            w_ff <= 32'h00000000;
            ws_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CFP_RESP_OKAY;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end
        else
        begin
            wr_en <= 1'b0;
            s_axi_awready <= !aw_have_ff && !s_axi_awready && !s_axi_bvalid && !wr_en;
            s_axi_wready <= !w_have_ff && !s_axi_wready && !s_axi_bvalid && !wr_en;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_ff <= 1'b1;
                aw_ff <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_ff <= 1'b1;
                w_ff <= s_axi_wdata;
                ws_ff <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_have_ff && w_have_ff && !s_axi_bvalid && !wr_en)
            begin
                wr_en <= 1'b1;
                wr_addr <= aw_ff;
                wr_data <= w_ff;
                wr_strb <= ws_ff;
            end
            if (wr_en)
            begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `CFP_RESP_OKAY : `CFP_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    // ====================================================================
    // Read channel: one cycle from address to data
    assign rd_addr = ar_ff;
    reg ar_have_ff;
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ar_ff <= 8'h00;
            ar_have_ff <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CFP_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !ar_have_ff && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                ar_ff <= s_axi_araddr;
                ar_have_ff <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            if (ar_have_ff)
            begin
                ar_have_ff <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? `CFP_RESP_OKAY : `CFP_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: src/cfp_core.v
// Instruction fetch port and clocking of a processor core, with register access
//
// Summary of operation
// - Outputs change, inputs sampled, on rising edge
// - Stretched clock tolerated; waits via enable input
// - Wait-state enable low freezes fetch and execute state; register writes still apply
// - State-advance output shows cycles that advance
// - Fetch address spans bits 31 to 1
// - Breakpointed fetch enters debug when executed
// - Request low when next cycle needs fetch
// - Five-bit mode valid with fetch address
// - Privilege low in user, high otherwise
// - Sequential high when next fetch follows last
// - ISA state high for compact instruction set
// - Cancel marks previous cycle request as void
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "cfp_regs.vh"
module cfp_core (
    input wire sys_clk,
    input wire rst_n,
    input wire wait_state_enable,
    output reg state_advance_out,
    output reg [31:1] fetch_address,
    input wire fetch_abort,
    input wire [31:0] fetch_data,
    input wire fetch_breakpoint,
    output reg fetch_request_n,
    output reg [4:0] fetch_mode,
    output reg fetch_privileged,
    output reg fetch_sequential,
    output reg fetch_isa_state,
    output reg fetch_cancel,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);
    // ====================================================================
    // Register bus
    wire wr_en;
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire [7:0] rd_addr;
    reg [31:0] rd_data;
    reg rd_ok;
    reg wr_ok;
    cfp_axil u_bus (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // ====================================================================
    // Control and state registers
    reg run_ff;
    reg isa_ff;
    reg [4:0] mode_ff;
    reg [31:0] target_ff;
    reg branch_req_ff;
    reg debug_ff;
    reg abort_seen_ff;
    reg [31:0] last_fetch_data_ff;
    reg [31:0] exec_pc_ff;
    reg [31:0] exec_count_ff;
    reg [31:0] pc_ff;
    reg pend_ff;
    reg due_ff;
    reg [31:0] pend_addr_ff;
    reg cancel_ff;

    // Pipeline advances only in cycles with the enable high
    wire adv = wait_state_enable;
    wire run_go = run_ff && !debug_ff;

    // ====================================================================
    // Fetched words queue toward execute; a stalled execute back-pressures fetch
    wire buf_in_ready;
    wire buf_out_valid;
    wire [33:0] buf_out_data;
    wire [31:0] buf_out_pc;
    reg [31:0] buf_pc_ff [0:1];
    reg bpw_ff;
    reg bpr_ff;
    // Take a word only for a live, non-cancelled request
    wire take = adv && due_ff && !cancel_ff && buf_in_ready;
    wire exec_ready = adv;
    cfp_buf2 #(
        .WIDTH(34)
    ) u_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(take),
        .in_ready(buf_in_ready),
        .in_data({fetch_breakpoint, fetch_abort, fetch_data}),
        .out_valid(buf_out_valid),
        .out_ready(exec_ready),
        .out_data(buf_out_data)
    );
    assign buf_out_pc = buf_pc_ff[bpr_ff];
    wire exec_fire = buf_out_valid && exec_ready;

    // Space check uses only the buffer's ready now; words still in flight are not counted
    wire want_fetch = run_go && !branch_req_ff && buf_in_ready;

    // ====================================================================
    // Next fetch state
    reg [31:0] nxt_pc;
    reg nxt_req;
    reg nxt_seq;
    reg nxt_cancel;
    always @*
    begin
        nxt_pc = pc_ff;
        nxt_req = 1'b0;
        nxt_seq = 1'b0;
        nxt_cancel = 1'b0;
        if (branch_req_ff)
        begin
            nxt_pc = target_ff;
            // A request already issued to the old stream is voided
            nxt_cancel = pend_ff;
        end
        else if (want_fetch)
        begin
            nxt_req = 1'b1;
            nxt_seq = pend_ff;
            nxt_pc = pend_ff ? pc_ff + (isa_ff ? 32'h00000002 : 32'h00000004) : pc_ff;
        end
    end

    // ====================================================================
    // Fetch port and core state; everything is on the rising edge
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_advance_out <= 1'b0;
            fetch_address <= 31'h00000000;
            fetch_request_n <= 1'b1;
            fetch_mode <= `CFP_MODE_SVC;
            fetch_privileged <= 1'b1;
            fetch_sequential <= 1'b0;
            fetch_isa_state <= 1'b0;
            fetch_cancel <= 1'b0;
            pc_ff <= `CFP_RESET_PC;
            pend_ff <= 1'b0;
            due_ff <= 1'b0;
            pend_addr_ff <= 32'h00000000;
            cancel_ff <= 1'b0;
            debug_ff <= 1'b0;
            abort_seen_ff <= 1'b0;
            last_fetch_data_ff <= 32'h00000000;
            exec_pc_ff <= 32'h00000000;
            exec_count_ff <= 32'h00000000;
            bpw_ff <= 1'b0;
            bpr_ff <= 1'b0;
            branch_req_ff <= 1'b0;
        end
        else
        begin
            state_advance_out <= adv;
            if (wr_en && wr_addr == `CFP_REG_CTRL && wr_strb[0] && wr_data[`CFP_CTRL_BRANCH])
                branch_req_ff <= 1'b1;
            // Clear first, so a same-cycle set below still wins
            if (wr_en && wr_addr == `CFP_REG_CTRL && wr_strb[0] && wr_data[`CFP_CTRL_DBGCLR])
            begin
                debug_ff <= 1'b0;
                abort_seen_ff <= 1'b0;
            end
            if (adv)
            begin
                if (branch_req_ff)
                    branch_req_ff <= 1'b0;
                pend_ff <= nxt_req;
                due_ff <= pend_ff;
                pend_addr_ff <= pc_ff;
                cancel_ff <= nxt_cancel;
                pc_ff <= nxt_pc;
                fetch_request_n <= !nxt_req;
                fetch_sequential <= nxt_seq;
                fetch_cancel <= nxt_cancel;
                fetch_address <= nxt_pc[31:1];
                fetch_mode <= mode_ff;
                fetch_privileged <= (mode_ff != `CFP_MODE_USER);
                fetch_isa_state <= isa_ff;
                if (take)
                begin
                    buf_pc_ff[bpw_ff] <= pend_addr_ff;
                    bpw_ff <= ~bpw_ff;
                end
                if (exec_fire)
                begin
                    bpr_ff <= ~bpr_ff;
                    exec_pc_ff <= buf_out_pc;
                    // Breakpoint acts only once its word reaches execute
                    if (buf_out_data[33])
                        debug_ff <= 1'b1;
                    else if (buf_out_data[32])
                        abort_seen_ff <= 1'b1;
                    else
                    begin
                        last_fetch_data_ff <= buf_out_data[31:0];
                        exec_count_ff <= exec_count_ff + 32'h00000001;
                    end
                end
            end
        end
    end

    // ====================================================================
    // Software registers
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            run_ff <= 1'b0;
            isa_ff <= 1'b0;
            mode_ff <= `CFP_MODE_SVC;
            target_ff <= `CFP_RESET_PC;
        end
        else if (wr_en)
        begin
            if (wr_addr == `CFP_REG_CTRL)
            begin
                if (wr_strb[0])
                begin
                    run_ff <= wr_data[`CFP_CTRL_RUN];
                    isa_ff <= wr_data[`CFP_CTRL_ISA];
                end
                if (wr_strb[1])
                    mode_ff <= wr_data[`CFP_CTRL_MODE_HI:`CFP_CTRL_MODE_LO];
            end
            else if (wr_addr == `CFP_REG_TARGET)
            begin
                if (wr_strb[0])
                    target_ff[7:0] <= wr_data[7:0];
                if (wr_strb[1])
                    target_ff[15:8] <= wr_data[15:8];
                if (wr_strb[2])
                    target_ff[23:16] <= wr_data[23:16];
                if (wr_strb[3])
                    target_ff[31:24] <= wr_data[31:24];
            end
        end
    end

    always @*
    begin
        wr_ok = (wr_addr == `CFP_REG_CTRL) || (wr_addr == `CFP_REG_TARGET);
        rd_ok = 1'b1;
        case (rd_addr)
            `CFP_REG_CTRL: rd_data = {19'h00000, mode_ff, 6'h00, isa_ff, run_ff};
            `CFP_REG_TARGET: rd_data = target_ff;
            `CFP_REG_STATUS: rd_data = {28'h0000000, buf_out_valid, run_go,
                abort_seen_ff, debug_ff};
            `CFP_REG_FETCH_DATA: rd_data = last_fetch_data_ff;
            `CFP_REG_PC: rd_data = exec_pc_ff;
            `CFP_REG_COUNT: rd_data = exec_count_ff;
            default:
            begin
                rd_data = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// file: sim/cfp_imem_model.sv
// Behavioural instruction memory and wait-state source for the fetch port
`timescale 1ns/100ps
`default_nettype none
module cfp_imem_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic [31:0] abort_addr,
    input wire logic [31:0] bkpt_addr,
    input wire logic [31:1] fetch_address,
    input wire logic fetch_request_n,
    output logic wait_state_enable,
    output logic [31:0] fetch_data,
    output logic fetch_abort,
    output logic fetch_breakpoint
);
    // ========================================
    // Answer one cycle after a request
    logic [31:0] addr_b;
    assign addr_b = {fetch_address, 1'h0};
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wait_state_enable <= 1'h1;
            fetch_data <= 32'h0;
            fetch_abort <= 1'h0;
            fetch_breakpoint <= 1'h0;
        end
        else
        begin
            // Slow mode stalls every other cycle, never part of one
            wait_state_enable <= slow ? ~wait_state_enable : 1'h1;
            // A cancelled request still gets its answer; the core must drop it
            if (wait_state_enable && !fetch_request_n)
            begin
                fetch_data <= addr_b ^ 32'hC3C3_0000;
                fetch_abort <= (addr_b == abort_addr);
                fetch_breakpoint <= (addr_b == bkpt_addr);
            end
            else if (wait_state_enable)
            begin
                // Idle lines flip so a stray sample never looks valid
                fetch_data <= ~fetch_data;
                fetch_abort <= ~fetch_abort;
                fetch_breakpoint <= ~fetch_breakpoint;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/cfp_fetch_assertions.sv
// Concurrent checks on the fetch port outputs of the core
`timescale 1ns/100ps
`default_nettype none
module cfp_fetch_assertions (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wait_state_enable,
    input wire logic state_advance_out,
    input wire logic [31:1] fetch_address,
    input wire logic fetch_request_n,
    input wire logic [4:0] fetch_mode,
    input wire logic fetch_privileged,
    input wire logic fetch_sequential,
    input wire logic fetch_isa_state,
    input wire logic fetch_cancel
);
    // ========================================
    // Properties
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_fetch_taken;
        wait_state_enable && !fetch_request_n;
    endsequence
    sequence s_seq_next;
        fetch_sequential && !fetch_request_n;
    endsequence
    a_stall_freeze:
        assert property (!wait_state_enable |=> $stable(fetch_address) && $stable(fetch_request_n)
            && $stable(fetch_sequential) && $stable(fetch_cancel))
        else $error("fetch outputs moved in a stalled cycle");
    a_mode_stall:
        assert property (!wait_state_enable |=> $stable(fetch_mode) && $stable(fetch_isa_state)
            && $stable(fetch_privileged))
        else $error("mode or isa moved in a stalled cycle");
    a_advance_echo:
        assert property ($past(rst_n) |-> state_advance_out == $past(wait_state_enable))
        else $error("state advance output does not follow the enable");
    a_priv_mode:
        assert property (fetch_privileged == (fetch_mode != 5'h10))
        else $error("privilege does not match mode");
    a_seq_step:
        assert property (s_fetch_taken ##1 s_seq_next |->
            fetch_address == $past(fetch_address) + (fetch_isa_state ? 31'h1 : 31'h2))
        else $error("sequential fetch address step wrong");
    a_cancel_pulse:
        assert property (fetch_cancel && wait_state_enable |=> !fetch_cancel)
        else $error("cancel longer than one advancing cycle");
    a_cancel_cause:
        assert property ($rose(fetch_cancel) |-> $past(fetch_request_n) == 1'h0)
        else $error("cancel without an outstanding request");
    a_cancel_quiet:
        assert property (fetch_cancel |-> fetch_request_n)
        else $error("new request in a cancel cycle");
endmodule
bind cfp_core cfp_fetch_assertions u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .wait_state_enable(wait_state_enable), .state_advance_out(state_advance_out),
    .fetch_address(fetch_address), .fetch_request_n(fetch_request_n),
    .fetch_mode(fetch_mode), .fetch_privileged(fetch_privileged),
    .fetch_sequential(fetch_sequential), .fetch_isa_state(fetch_isa_state),
    .fetch_cancel(fetch_cancel));
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the fetch port core
`timescale 1ns/100ps
`default_nettype none
`include "cfp_regs.vh"
module testbench;
    logic sys_clk, rst_n, slow, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata_q, abort_addr, bkpt_addr, pc;
    logic [1:0] resp_q;
    wire wse, adv, req_n, abt, bkp, priv, seq, isa, cncl;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, fdata;
    wire [31:1] fetch_address;
    wire [4:0] mode;
    integer mismatches, samples_checked, cycles, i;
    cfp_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .wait_state_enable(wse),
        .state_advance_out(adv), .fetch_address(fetch_address), .fetch_abort(abt),
        .fetch_data(fdata), .fetch_breakpoint(bkp), .fetch_request_n(req_n),
        .fetch_mode(mode), .fetch_privileged(priv), .fetch_sequential(seq),
        .fetch_isa_state(isa), .fetch_cancel(cncl), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    cfp_imem_model u_mem (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
        .abort_addr(abort_addr), .bkpt_addr(bkpt_addr), .fetch_address(fetch_address),
        .fetch_request_n(req_n), .wait_state_enable(wse), .fetch_data(fdata),
        .fetch_abort(abt), .fetch_breakpoint(bkp));
    // ========================================
    // Clock, timeout and common tasks
    initial
    begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    task end_of_test;
        begin
            if (mismatches == 0 && samples_checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            end_of_test;
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp)
            begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge sys_clk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            @(posedge sys_clk);
            while (bready)
            begin
                if (awready)
                    awvalid <= 1'h0;
                if (wready)
                    wvalid <= 1'h0;
                if (bvalid)
                begin
                    bready <= 1'h0;
                    resp_q = bresp;
                end
                @(posedge sys_clk);
            end
        end
    endtask
    task axi_rd(input logic [7:0] a);
        begin
            @(posedge sys_clk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            @(posedge sys_clk);
            while (rready)
            begin
                if (arready)
                    arvalid <= 1'h0;
                if (rvalid)
                begin
                    rready <= 1'h0;
                    rdata_q = rdata;
                    resp_q = rresp;
                end
                @(posedge sys_clk);
            end
        end
    endtask
    // Branch to a target with run set, then wait for the first request
    task go(input logic [31:0] tgt, input logic [31:0] ctrl);
        integer n;
        begin
            axi_wr(`CFP_REG_TARGET, tgt);
            axi_wr(`CFP_REG_CTRL, ctrl | 32'h5);
            n = 0;
            while (req_n !== 1'h0 && n < 100)
            begin
                @(posedge sys_clk);
                n = n + 1;
            end
            chk("branch_address", {fetch_address, 1'h0}, tgt);
        end
    endtask
    task stop;
        begin
            axi_wr(`CFP_REG_CTRL, 32'h1300);
            repeat (10) @(posedge sys_clk);
            chk("idle_request_n", req_n, 1);
        end
    endtask
    // ========================================
    // Scenarios
    task t_regs;
        begin
            axi_rd(`CFP_REG_CTRL);
            chk("ctrl_reset", rdata_q, 32'h1300);
            axi_rd(8'h18);
            chk("unmapped_rresp", resp_q, 2'h2);
            chk("unmapped_rdata", rdata_q, 32'h0);
            axi_wr(8'h1C, 32'hFFFF_FFFF);
            chk("unmapped_bresp", resp_q, 2'h2);
        end
    endtask
    task t_run;
        begin
            go(32'h100, 32'h1300);
            repeat (10) @(posedge sys_clk);
            go(32'h180, 32'h1300);
            repeat (10) @(posedge sys_clk);
            stop;
            axi_rd(`CFP_REG_PC);
            pc = rdata_q;
            axi_rd(`CFP_REG_FETCH_DATA);
            chk("executed_word", rdata_q, pc ^ 32'hC3C3_0000);
            axi_rd(`CFP_REG_COUNT);
            chk("count_nonzero", rdata_q != 0, 1);
        end
    endtask
    task t_mode;
        logic [4:0] m;
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                m = i[0] ? 5'h1F : 5'h10;
                go(32'h200, {19'h0, m, 8'h0} | (i[1] ? 32'h2 : 32'h0));
                repeat (6) @(posedge sys_clk);
                chk("mode", mode, m);
                chk("privileged", priv, m != 5'h10);
                chk("isa_state", isa, i[1]);
            end
            stop;
        end
    endtask
    task t_stall;
        logic w;
        begin
            slow <= 1'h1;
            go(32'h240, 32'h1300);
            repeat (8)
            begin
                @(posedge sys_clk);
                w = wse;
                #1 chk("state_advance", adv, w);
            end
            stop;
            slow <= 1'h0;
        end
    endtask
    task t_fault(input logic [31:0] start, input integer bitn);
        begin
            go(start, 32'h1300);
            repeat (30) @(posedge sys_clk);
            if (bitn == 0)
                chk("debug_halts_fetch", req_n, 1);
            axi_rd(`CFP_REG_STATUS);
            chk("status_set", rdata_q[bitn], 1);
            axi_wr(`CFP_REG_CTRL, 32'h1308);
            axi_rd(`CFP_REG_STATUS);
            chk("status_clear", rdata_q[bitn], 0);
            abort_addr <= 32'hFFFF_FFF0;
            bkpt_addr <= 32'hFFFF_FFF0;
        end
    endtask
    initial
    begin
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        {rst_n, slow, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {awaddr, araddr, wdata} = 48'h0;
        abort_addr = 32'hFFFF_FFF0;
        bkpt_addr = 32'hFFFF_FFF0;
        repeat (8) @(posedge sys_clk);
        chk("reset_request_n", req_n, 1);
        chk("reset_cancel", cncl, 0);
        chk("reset_mode", mode, 5'h13);
        chk("reset_privileged", priv, 1);
        chk("reset_isa", isa, 0);
        rst_n <= 1'h1;
        t_regs;
        t_run;
        t_mode;
        t_stall;
        abort_addr <= 32'h300;
        t_fault(32'h2F8, 1);
        bkpt_addr <= 32'h400;
        t_fault(32'h3F0, 0);
        end_of_test;
    end
endmodule
`default_nettype wire
